/* File: logic/count_if.sv */
// Write and readback carrier between the scheduler and the byte-count store
interface count_if;
  logic       wr_en;
  logic [2:0] wr_idx;
  logic [7:0] wr_data;
  logic [2:0] rd_idx;
  logic [7:0] rd_data;
  modport writer (output wr_en, wr_idx, wr_data, rd_idx, input rd_data);
  modport store  (input wr_en, wr_idx, wr_data, rd_idx, output rd_data);
endinterface : count_if

/* File: logic/iso_count_mem.sv */
// Eight-entry store of received byte counts, registered read
module iso_count_mem (
  input wire logic core_clk,
  input wire logic rst,
  count_if.store   port
);
  logic [7:0] mem [8];

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 8; i++) begin
        mem[i] <= iso_split_pkg::COUNT_RESET;
      end
    end else if (port.wr_en) begin
      mem[port.wr_idx] <= port.wr_data;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      port.rd_data <= iso_split_pkg::COUNT_RESET;
    end else begin
      port.rd_data <= mem[port.rd_idx];
    end
  end
endmodule : iso_count_mem

/* File: logic/iso_split_descriptor_sched.sv */
// Per-microframe scheduler for an isochronous split descriptor
module iso_split_descriptor_sched (
  input  wire logic        core_clk,
  input  wire logic        rst,
  // Descriptor load from software
  input  wire logic        load,
  input  wire logic [7:0]  load_ss_mask,
  input  wire logic [7:0]  load_cs_mask,
  input  wire logic [7:0]  load_uframe_byte,
  input  wire logic [1:0]  load_token,
  input  wire logic        load_active,
  // Bus timing
  input  wire logic        uframe_start,
  input  wire logic [4:0]  bus_frame,
  input  wire logic [2:0]  bus_uframe,
  // Transaction translator side
  input  wire logic        xfer_done,
  input  wire logic [7:0]  xfer_bytes,
  input  wire logic        xfer_err,
  input  wire logic        xfer_babble,
  input  wire logic        xfer_underrun,
  input  wire logic        xfer_stall,
  // Count readback
  input  wire logic [2:0]  count_sel,
  // Split requests toward the translator
  output logic             issue_ss,
  output logic             issue_cs,
  output logic [2:0]       issue_uframe,
  // Descriptor status written back
  output logic [7:0]       start_split_uframe_mask,
  output logic [7:0]       complete_split_uframe_mask,
  output logic [23:0]      uframe_results,
  output logic             active,
  output logic             halt,
  output logic             babble,
  output logic             xact_err,
  output logic             split_phase_flag,
  // Registered byte count readback
  output logic [7:0]       count_data
);
  // Flow: load a descriptor, wait for a microframe start that a mask and
  // the frame number select, issue one split, and on its answer write the
  // status, clear the mask bit and, after a start split, store the byte count
  iso_split_pkg::sched_state_type state;
  logic [1:0] token;
  logic [4:0] desc_frame;
  logic       cur_cs;
  logic [2:0] cur_uf;

  // Store for the eight received byte counts
  count_if cnt ();

  iso_count_mem u_mem (
    .core_clk (core_clk),
    .rst      (rst),
    .port     (cnt.store)
  );

  // Token decode; any code but IN is handled as OUT
  function automatic logic is_in(input logic [1:0] t);
    return t == iso_split_pkg::TOKEN_IN;
  endfunction : is_in

  // Bit b of the status field of microframe u
  function automatic logic res_bit(input logic [23:0] r,
                                   input logic [2:0]  u,
                                   input int          b);
    return r[int'(u) * 3 + b];
  endfunction : res_bit

  // Lowest bit of microframe u's status field
  function automatic int res_lsb(input logic [2:0] u);
    return int'(u) * 3;
  endfunction : res_lsb

  logic frame_ok;
  logic ss_hit;
  logic cs_hit;
  logic [2:0] new_res;
  logic [7:0] sum_err;
  logic [7:0] sum_bab;
  logic       xfer_end;
  logic       take;
  logic       ss_left;
  logic       cs_left;

  // No split goes out unless the descriptor's frame is the bus frame
  assign frame_ok = bus_frame == desc_frame;
  assign ss_hit = start_split_uframe_mask[bus_uframe] && frame_ok;
  // Complete splits only exist on IN
  assign cs_hit = is_in(token) &&
                  complete_split_uframe_mask[bus_uframe] && frame_ok;

  // A microframe start is only taken while waiting on a live descriptor
  assign take = state == iso_split_pkg::ST_WAIT && active &&
                uframe_start && (ss_hit || cs_hit);
  assign xfer_end = state == iso_split_pkg::ST_XFER && xfer_done;

  // Splits still owed; an OUT never waits on its complete-split mask
  assign ss_left = start_split_uframe_mask != 8'h00;
  assign cs_left = is_in(token) && complete_split_uframe_mask != 8'h00;

  // Babble has meaning only on IN and underrun only on OUT, so the other
  // token's bit stays low whatever the translator reports
  always_comb begin
    new_res = 3'h0;
    new_res[iso_split_pkg::RES_ERR_BIT] = xfer_err;
    if (is_in(token)) begin
      new_res[iso_split_pkg::RES_BABBLE_BIT] = xfer_babble;
    end else begin
      new_res[iso_split_pkg::RES_UNDER_BIT] = xfer_underrun;
    end
  end

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      sum_err[i] = res_bit(uframe_results, 3'(i),
                           iso_split_pkg::RES_ERR_BIT);
      sum_bab[i] = res_bit(uframe_results, 3'(i),
                           iso_split_pkg::RES_BABBLE_BIT);
    end
  end

  // Scheduler state
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state <= iso_split_pkg::ST_IDLE;
    end else begin
      unique case (state)
        iso_split_pkg::ST_IDLE: begin
          // A load with the active flag low leaves the descriptor parked
          if (load && load_active) begin
            state <= iso_split_pkg::ST_WAIT;
          end
        end
        iso_split_pkg::ST_WAIT: begin
          if (!active) begin
            state <= iso_split_pkg::ST_IDLE;
          end else if (take) begin
            state <= iso_split_pkg::ST_XFER;
          end
        end
        iso_split_pkg::ST_XFER: begin
          // No timeout here: a split the translator never answers hangs
          if (xfer_done) begin
            state <= iso_split_pkg::ST_WAIT;
          end
        end
        default: state <= iso_split_pkg::ST_IDLE;
      endcase
    end
  end

  // Split in flight; a start split wins when both masks select the same
  // microframe
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cur_cs <= 1'b0;
      cur_uf <= 3'h0;
    end else if (take) begin
      cur_cs <= !ss_hit;
      cur_uf <= bus_uframe;
    end
  end

  // Issue strobes stand for one cycle after the microframe start is taken;
  // the microframe number stays until the next split
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      issue_ss     <= 1'b0;
      issue_cs     <= 1'b0;
      issue_uframe <= 3'h0;
    end else begin
      issue_ss <= take && ss_hit;
      issue_cs <= take && !ss_hit;
      if (take) begin
        issue_uframe <= bus_uframe;
      end
    end
  end

  // Token of the loaded descriptor
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      token <= iso_split_pkg::TOKEN_OUT;
    end else if (load) begin
      token <= load_token;
    end
  end

  // Frame in which the descriptor executes
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      desc_frame <= 5'h00;
    end else if (load) begin
      desc_frame <= load_uframe_byte[7:iso_split_pkg::FRAME_LSB];
    end
  end

  // Start-split mask: software loads it, each start split clears its bit
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      start_split_uframe_mask <= iso_split_pkg::MASK_RESET;
    end else if (load) begin
      start_split_uframe_mask <= load_ss_mask;
    end else if (xfer_end && !cur_cs) begin
      start_split_uframe_mask[cur_uf] <= 1'b0;
    end
  end

  // Complete-split mask: each complete split clears its own bit
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      complete_split_uframe_mask <= iso_split_pkg::MASK_RESET;
    end else if (load) begin
      complete_split_uframe_mask <= load_cs_mask;
    end else if (xfer_end && cur_cs) begin
      complete_split_uframe_mask[cur_uf] <= 1'b0;
    end
  end

  // Per-microframe status, cleared by every load
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      uframe_results <= iso_split_pkg::RESULT_RESET;
    end else if (load) begin
      uframe_results <= iso_split_pkg::RESULT_RESET;
    end else if (xfer_end) begin
      uframe_results[res_lsb(cur_uf) +: 3] <= new_res;
    end
  end

  // A stall reported in the cycle of a load still sets halt, so a stalled
  // endpoint is never lost
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      halt <= 1'b0;
    end else if (xfer_end && xfer_stall) begin
      halt <= 1'b1;
    end else if (load) begin
      halt <= 1'b0;
    end
  end

  // Split phase follows the kind of the last split issued
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      split_phase_flag <= 1'b0;
    end else if (load) begin
      split_phase_flag <= 1'b0;
    end else if (issue_ss || issue_cs) begin
      split_phase_flag <= issue_cs;
    end
  end

  // Summaries lag the status fields by one cycle
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      babble <= 1'b0;
    end else begin
      babble <= |sum_bab;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      xact_err <= 1'b0;
    end else begin
      xact_err <= |sum_err;
    end
  end

  // Active drops once no split is owed, and one cycle after halt rises so a stalled
  // endpoint is not polled again
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      active <= 1'b0;
    end else if (load) begin
      active <= load_active;
    end else if (halt) begin
      active <= 1'b0;
    end else if (!ss_left && !cs_left &&
                 state == iso_split_pkg::ST_WAIT) begin
      active <= 1'b0;
    end
  end

  // Counts land only for a start split whose mask bit is still set; a
  // complete split leaves the stored counts alone
  assign cnt.wr_en   = xfer_end && !cur_cs &&
                       start_split_uframe_mask[cur_uf];
  assign cnt.wr_idx  = cur_uf;
  assign cnt.wr_data = xfer_bytes;

  // Readback comes from the store's read register, one cycle behind
  assign cnt.rd_idx  = count_sel;
  assign count_data  = cnt.rd_data;
endmodule : iso_split_descriptor_sched

/* File: logic/iso_split_pkg.sv */
// Constants and types for the isochronous split descriptor scheduler
// Notes on behaviour
// - Store received bytes per microframe when scheduled, frame matches
// - Complete-split mask, one bit per microframe, cleared
// - Complete-split mask used only for IN
// - Start in uframe0, complete in uframe2 example works
// - Three-bit status per microframe, seven highest
// - Status bits: error, babble on IN, underrun on OUT
// - Start-split mask selects start microframes, cleared after
// - OUT sends only when frame number matches bus
// - Active flag cleared by controller on completion
// - Halt set on any stalled microframe
// - Babble summary from status bit one
// - Error summary from status bit zero
// - Frame number taken from uframe byte bits seven-three
// - Token code 00 is OUT, 01 is IN
package iso_split_pkg;
  localparam int          UFRAMES       = 8;
  localparam int          FRAME_LSB     = 3;
  localparam int          FRAME_W       = 5;
  localparam logic [1:0]  TOKEN_OUT     = 2'h0;
  localparam logic [1:0]  TOKEN_IN      = 2'h1;
  localparam int          RES_ERR_BIT   = 0;
  localparam int          RES_BABBLE_BIT = 1;
  localparam int          RES_UNDER_BIT = 2;
  localparam logic [7:0]  MASK_RESET    = 8'h00;
  localparam logic [23:0] RESULT_RESET  = 24'h000000;
  localparam logic [7:0]  COUNT_RESET   = 8'h00;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_WAIT = 3'h2,
    ST_XFER = 3'h4
  } sched_state_type;
endpackage : iso_split_pkg

/* File: verif/iso_split_descriptor_sched_tb.sv */
// Self-checking bench for the split descriptor scheduler
module iso_split_descriptor_sched_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic        load = 1'b0;
  logic        ust = 1'b0;
  logic [7:0]  ssm = 8'h00;
  logic [7:0]  csm = 8'h00;
  logic [7:0]  ub = 8'h00;
  logic [1:0]  tok = 2'h0;
  logic [4:0]  bf = 5'h00;
  logic [2:0]  bu = 3'h0;
  logic [2:0]  sel = 3'h0;
  logic [2:0]  dly = 3'h1;
  logic [11:0] resp = 12'h000;
  logic        la = 1'b1;
  logic [11:0] info;
  logic        xd, iss, ics, act, hlt, bab, xer, spf;
  logic [2:0]  iu;
  logic [7:0]  sm, cm, cd;
  logic [23:0] res;
  logic [1:0]  g;
  int          num_checks = 0;
  int          miscompares = 0;

  iso_split_descriptor_sched dut_u (
    .core_clk, .rst, .load, .load_ss_mask(ssm), .load_cs_mask(csm),
    .load_uframe_byte(ub), .load_token(tok), .load_active(la),
    .uframe_start(ust), .bus_frame(bf), .bus_uframe(bu), .xfer_done(xd),
    .xfer_bytes(info[7:0]), .xfer_err(info[8]), .xfer_babble(info[9]),
    .xfer_underrun(info[10]), .xfer_stall(info[11]), .count_sel(sel),
    .issue_ss(iss), .issue_cs(ics), .issue_uframe(iu),
    .start_split_uframe_mask(sm), .complete_split_uframe_mask(cm),
    .uframe_results(res), .active(act), .halt(hlt), .babble(bab),
    .xact_err(xer), .split_phase_flag(spf), .count_data(cd));
  iso_tt_model tt_u (.core_clk, .rst, .issue(iss | ics), .dly, .resp,
    .done(xd), .info);

  always #10 core_clk = ~core_clk;

  task chk(input logic [23:0] got, input logic [23:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task test_done;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : test_done

  task ld(input logic [1:0] t, input logic [7:0] s, input logic [7:0] c,
          input logic [4:0] f);
    @(negedge core_clk);
    tok = t;
    ssm = s;
    csm = c;
    ub = {f, 3'h0};
    load = 1'b1;
    @(negedge core_clk);
    load = 1'b0;
  endtask : ld

  // One microframe start; reports which split went out, waits its answer
  task uf(input logic [2:0] u, input logic [4:0] f, output logic [1:0] got);
    logic dn;
    got = 2'h0;
    dn = 1'b0;
    @(negedge core_clk);
    bu = u;
    bf = f;
    ust = 1'b1;
    @(negedge core_clk);
    ust = 1'b0;
    for (int i = 0; i < 14; i++) begin
      if ((iss | ics) === 1'b1) begin
        got = {ics, iss};
        chk(iu, u);
      end
      dn = dn | (xd === 1'b1);
      @(negedge core_clk);
    end
    if (got != 2'h0 && !dn) begin
      miscompares++;
      test_done;
    end
  endtask : uf

  task t_out;
    resp = 12'h411;
    la = 1'b0;
    ld(iso_split_pkg::TOKEN_OUT, 8'h01, 8'h04, 5'h05);
    chk(act, 1'b0);
    uf(3'h0, 5'h05, g);
    chk(g, 2'h0);
    la = 1'b1;
    ld(iso_split_pkg::TOKEN_OUT, 8'h01, 8'h04, 5'h05);
    chk(act, 1'b1);
    uf(3'h0, 5'h06, g);
    chk(g, 2'h0);
    uf(3'h2, 5'h05, g);
    chk(g, 2'h0);
    uf(3'h0, 5'h05, g);
    chk(g, 2'h1);
    chk(sm, 8'h00);
    chk(res, 24'h000004);
    chk(act, 1'b0);
  endtask : t_out

  task t_in;
    dly = 3'h5;
    resp = 12'h33C;
    ld(iso_split_pkg::TOKEN_IN, 8'h02, 8'h08, 5'h02);
    uf(3'h1, 5'h02, g);
    chk(g, 2'h1);
    chk(spf, 1'b0);
    chk(res, 24'h000018);
    chk(bab, 1'b1);
    chk(xer, 1'b1);
    sel = 3'h1;
    repeat (2) @(negedge core_clk);
    chk(cd, 8'h3C);
    resp = 12'h8AA;
    uf(3'h3, 5'h02, g);
    chk(g, 2'h2);
    chk(spf, 1'b1);
    chk(cm, 8'h00);
    chk(res, 24'h000018);
    chk(hlt, 1'b1);
    chk(act, 1'b0);
    sel = 3'h3;
    repeat (2) @(negedge core_clk);
    chk(cd, 8'h00);
  endtask : t_in

  initial begin
    repeat (8) @(negedge core_clk);
    rst = 1'b0;
    t_out;
    t_in;
    test_done;
  end
endmodule : iso_split_descriptor_sched_tb

/* File: verif/iso_split_sched_checker.sv */
// Port-level assertions for the split descriptor scheduler
module iso_split_sched_checker (
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        load,
  input wire logic [1:0]  load_token,
  input wire logic        uframe_start,
  input wire logic [2:0]  bus_uframe,
  input wire logic        xfer_done,
  input wire logic        xfer_stall,
  input wire logic        issue_ss,
  input wire logic        issue_cs,
  input wire logic [2:0]  issue_uframe,
  input wire logic [7:0]  start_split_uframe_mask,
  input wire logic [23:0] uframe_results,
  input wire logic        halt,
  input wire logic        babble,
  input wire logic        xact_err,
  input wire logic        split_phase_flag
);
  logic [1:0] tok;
  wire logic  bab_any = |(uframe_results & 24'h492492);
  wire logic  err_any = |(uframe_results & 24'h249249);
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) tok <= 2'h0;
    else if (load) tok <= load_token;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  property p_ss_cause;
    issue_ss |-> $past(uframe_start) || $past(uframe_start, 2);
  endproperty
  a_ss_cause: assert property (p_ss_cause)
    else $error("start split without microframe start");
  property p_cs_in;
    issue_cs |-> tok == iso_split_pkg::TOKEN_IN;
  endproperty
  a_cs_in: assert property (p_cs_in)
    else $error("complete split on an OUT descriptor");
  property p_uf;
    (issue_ss || issue_cs) |-> issue_uframe == $past(bus_uframe);
  endproperty
  a_uf: assert property (p_uf)
    else $error("split issued in wrong microframe");
  property p_ss_clr;
    xfer_done && !split_phase_flag
      |-> ##[1:2] !start_split_uframe_mask[issue_uframe];
  endproperty
  a_ss_clr: assert property (p_ss_clr)
    else $error("start mask bit not cleared");
  property p_bab;
    babble == $past(bab_any);
  endproperty
  a_bab: assert property (p_bab)
    else $error("babble summary wrong");
  property p_err;
    xact_err == $past(err_any);
  endproperty
  a_err: assert property (p_err)
    else $error("error summary wrong");
  property p_halt;
    xfer_done && xfer_stall |-> ##[1:2] halt;
  endproperty
  a_halt: assert property (p_halt)
    else $error("halt not set on stall");
  property p_kind;
    (uframe_results & (tok == iso_split_pkg::TOKEN_OUT ?
      24'h492492 : 24'h924924)) == 24'h000000;
  endproperty
  a_kind: assert property (p_kind)
    else $error("status bit used for wrong token");
endmodule : iso_split_sched_checker

bind iso_split_descriptor_sched iso_split_sched_checker chk_u (
  .core_clk, .rst, .load, .load_token, .uframe_start, .bus_uframe,
  .xfer_done, .xfer_stall, .issue_ss, .issue_cs, .issue_uframe,
  .start_split_uframe_mask, .uframe_results, .halt, .babble, .xact_err,
  .split_phase_flag);

/* File: verif/iso_tt_model.sv */
// Behavioural translator answering each issued split
module iso_tt_model (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        issue,
  input  wire logic [2:0]  dly,
  input  wire logic [11:0] resp,
  output logic             done,
  output logic [11:0]      info
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] wait_cnt;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      done <= 1'b0;
      wait_cnt <= 3'h0;
      info <= 12'h000;
    end else begin
      done <= 1'b0;
      // Toggle so no stale answer ever looks valid
      info <= ~info;
      if (issue) wait_cnt <= dly;
      else if (wait_cnt != 3'h0) begin
        wait_cnt <= wait_cnt - 3'h1;
        if (wait_cnt == 3'h1) begin
          done <= 1'b1;
          info <= resp;
        end
      end
    end
  end
endmodule : iso_tt_model
